// ---- design/hbw_pkg.sv ----
/*
  hbw_pkg: constants shared by both ends of the host bus window port.
  assumes: one 40 MHz clock, host word accesses only.
*/
package hbw_pkg;
  // ==========================================================
  // window layout (byte offsets inside the 64k window)
  localparam logic [15:0] OFS_MOVABLE_LO = 16'h0000; // movable data area start
  localparam logic [15:0] OFS_FIXED_LO = 16'h8000; // fixed data area start
  localparam logic [15:0] OFS_SEGMENT = 16'hc000; // movable segment pointer
  localparam logic [15:0] OFS_NMI = 16'hc800; // board nmi trigger
  localparam logic [15:0] OFS_IRQ_CLEAR = 16'hd000; // host interrupt clear
  localparam logic [15:0] OFS_STATUS = 16'hd800; // board status
  localparam logic [15:0] OFS_RESET = 16'he000; // processor reset control
  localparam logic [15:0] OFS_PROC_INT = 16'he800; // processor maskable interrupt
  // ==========================================================
  // bases (upper eight host address bits, seven for the high base)
  localparam logic [7:0] BASE_LOW_A = 8'h0a; // 0a0000
  localparam logic [7:0] BASE_LOW_B = 8'h0d; // 0d0000
  localparam logic [6:0] BASE_HIGH7 = 7'h50; // a00000 with line 16 ignored
  // ==========================================================
  // board address forming
  localparam logic [10:0] FIXED_POINTER = 11'h237; // 46e000 >> 13
  localparam int SEG_FIELD_W = 10; // segment pointer bits
  localparam logic [15:0] SEG_DEFINED_MASK = 16'h03db; // bits 2,5,10..15 undefined
  localparam logic [15:0] SEG_RESET = 16'h0000; // segment reset value
  // status bit positions
  localparam int ST_RESET_BIT = 3;
  localparam int ST_HALT_BIT = 2;
  localparam int ST_PINT_BIT = 1;
  localparam int ST_HIRQ_BIT = 0;
  // ==========================================================
  // timing
  localparam int CLK_PERIOD_NS = 25; // 40 MHz
  localparam int NMI_PULSE_NS = 100; // short nmi pulse
  localparam int NMI_PULSE_CYC = (NMI_PULSE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int RESET_HOLD_NS = 800; // least reset hold time
  localparam int RESET_HOLD_CYC = (RESET_HOLD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  // avalon command codes for the host controller
  localparam logic [3:0] CSR_CMD = 4'h0; // write: go, read: busy
  localparam logic [3:0] CSR_ADDR = 4'h1; // host byte address 23:0
  localparam logic [3:0] CSR_WDATA = 4'h2; // write data
  localparam logic [3:0] CSR_RDATA = 4'h3; // read data of last access
  localparam logic [3:0] CSR_IRQ = 4'h4; // bit0 host irq line seen
endpackage : hbw_pkg

// ---- design/hbw_link_if.sv ----
/*
  hbw_link_if: host expansion bus and board side wires between the ends.
  assumes: the bench drives ref_clk_in and reset_in into both ends.
*/
`timescale 1ns/1ps
interface hbw_link_if;
  logic [23:0] host_addr; // host address lines
  logic aen; // address enable, low for memory cycles
  logic bale; // address latch strobe
  logic mem_rd_n; // memory read strobe
  logic mem_wr_n; // memory write strobe
  logic [15:0] wdata; // host write data
  logic [15:0] rdata; // board read data
  logic rdata_oe; // board drives data
  logic ready; // high when the board releases the host
  logic word_capable_select_n; // 16-bit capable indication
  logic host_irq; // board interrupt toward host
  modport board (input host_addr, aen, bale, mem_rd_n, mem_wr_n, wdata,
    output rdata, rdata_oe, ready, word_capable_select_n, host_irq);
  modport host (output host_addr, aen, bale, mem_rd_n, mem_wr_n, wdata,
    input rdata, rdata_oe, ready, word_capable_select_n, host_irq);
endinterface : hbw_link_if

// ---- design/hbw_addr_former.sv ----
/*
  hbw_addr_former: forms the 24-bit board address from host address.
  assumes: inputs already stable for the cycle.
*/
`timescale 1ns/1ps
module hbw_addr_former
  import hbw_pkg::*;
(
  input wire logic [15:0] host_ofs_in,
  input wire logic [15:0] segment_in,
  output logic [23:0] board_addr_out,
  output logic fixed_area_out
);
  // ==========================================================
  // address mapping
  wire fixed_area = host_ofs_in[15]; // 8000..fffe is fixed area (offset bit 15 alone)
  assign fixed_area_out = fixed_area;
  // movable: upper ten from segment, lower 14 from host lines 14:1; see R11 see R12
  wire [23:0] movable_addr = {segment_in[9:0], host_ofs_in[14:1]};
  // fixed: eleven pointer bits and host lines 13:1; see R15 see R16
  wire [23:0] fixed_addr = {FIXED_POINTER, host_ofs_in[13:1]};
  // lines 16 and 19 are not driven by the board; see R14
  wire [23:0] raw_addr = fixed_area ? fixed_addr : movable_addr;
  assign board_addr_out = raw_addr & 24'hf6ffff;
endmodule : hbw_addr_former

// ---- design/hbw_board_end.sv ----
/*
  hbw_board_end: board side of the host window port with arbiter handshake.
  assumes: one 40 MHz clock, host obeys word accesses, arbiter answers grant.
*/
// Design decisions made here: the placing of the registers and the Avalon-MM register port.
// Summary of operation
// R1 - select only when aen low, latched by strobe
// R2 - three jumper bases, any combination enabled
// R3 - installer should avoid the two low bases
// R4 - host uses word accesses, address bit zero low
// R5 - word indication from upper seven lines only
// R6 - late indication makes host split into bytes
// R7 - low megabyte window ignores address line 16
// R8 - high base decodes 128k double image
// R9 - hold host, request arbiter, transfer, release
// R10 - segment takes data 9:0 as address 23:14
// R11 - movable access: segment upper, host lower
// R12 - host line 1 maps to board line 0
// R13 - segment readback undefined bits 2,5,10-15
// R14 - board address lines 16 and 19 unused
// R15 - fixed window covers 46e000 to 46ffff
// R16 - fixed pointer eleven bits, host 13:1
// R17 - host resets, interrupts, reads board status
// R18 - processor raises host irq, host clears
// R19 - processor address latches float during host access
// R20 - nmi location write pulses processor nmi
// R21 - irq clear location write drops host irq
// R22 - status returns reset, halt, int, host irq
// R23 - host holds reset one for 800 ns
`timescale 1ns/1ps
module hbw_board_end
  import hbw_pkg::*;
(
  input wire logic ref_clk_in,
  input wire logic reset_in,
  hbw_link_if.board link,
  input wire logic jumper_base_low_a, // enables base 0a0000
  input wire logic jumper_base_low_b, // enables base 0d0000
  input wire logic jumper_base_high, // enables base a00000
  input wire logic grant_in, // arbiter grants remote cycle
  input wire logic [15:0] mem_rdata_in, // board memory read data
  input wire logic proc_halt_in, // processor halt state
  input wire logic proc_irq_raise_in, // processor writes its host irq register
  input wire logic proc_int_clear_in, // processor withdraws its maskable irq
  output logic request_out, // remote access request
  output logic [23:0] board_addr_out,
  output logic board_we_out,
  output logic [15:0] board_wdata_out,
  output logic proc_bus_oe_out, // processor address latches and buffers enabled
  output logic processor_reset_ctl, // processor reset
  output logic proc_nmi_out, // processor nmi pulse
  output logic proc_int_out // processor maskable irq
);
  import hbw_pkg::*;
  typedef enum logic [1:0] {ST_IDLE, ST_WAIT, ST_DONE} hbw_state_e;
  // ==========================================================
  // board select decode
  // host address line 16 ignored on every base; see R5 see R7 see R8
  wire [6:0] up7 = link.host_addr[23:17];
  wire hit_low_a = jumper_base_low_a && (up7 == BASE_LOW_A[7:1]); // see R2
  wire hit_low_b = jumper_base_low_b && (up7 == BASE_LOW_B[7:1]); // see R2
  wire hit_high = jumper_base_high && (up7 == BASE_HIGH7); // see R2 see R8
  wire decode_hit = hit_low_a || hit_low_b || hit_high;
  // word capable purely from decode; see R5
  assign link.word_capable_select_n = !decode_hit;
  logic board_select_latched_n; // transparent latch in clocked form
  // follow decode while strobe high, hold otherwise; see R1
  always_ff @(posedge ref_clk_in or posedge reset_in) begin
    if (reset_in) begin
      board_select_latched_n <= 1'b1;
    end else if (link.bale) begin
      board_select_latched_n <= !(decode_hit && !link.aen);
    end
  end
  // ==========================================================
  // register and area decode
  wire [15:0] ofs = link.host_addr[15:0];
  wire strobe = !link.mem_rd_n || !link.mem_wr_n;
  wire sel = !board_select_latched_n && !link.aen && strobe;
  wire is_write = !link.mem_wr_n;
  wire mem_area = !ofs[15] || (ofs[15:14] == 2'b10);
  wire hit_seg = ofs[15:11] == OFS_SEGMENT[15:11];
  wire hit_nmi = ofs[15:11] == OFS_NMI[15:11];
  wire hit_clr = ofs[15:11] == OFS_IRQ_CLEAR[15:11];
  wire hit_stat = ofs[15:11] == OFS_STATUS[15:11];
  wire hit_rst = ofs[15:11] == OFS_RESET[15:11];
  wire hit_pint = ofs[15:11] == OFS_PROC_INT[15:11];
  logic [15:0] movable_segment_pointer; // movable segment register
  logic host_irq_flag; // board interrupt toward host
  logic [7:0] nmi_cnt; // nmi pulse length counter
  hbw_state_e state;
  hbw_state_e next_state;
  wire [23:0] formed_addr;
  hbw_addr_former u_addr (
    .host_ofs_in(ofs),
    .segment_in(movable_segment_pointer),
    .board_addr_out(formed_addr),
    .fixed_area_out()
  );
  // ==========================================================
  // access state machine; see R9
  wire start = (state == ST_IDLE) && sel;
  always_comb begin
    next_state = state;
    case (state)
      ST_IDLE: if (sel) begin
        next_state = mem_area ? ST_WAIT : ST_DONE;
      end
      ST_WAIT: if (grant_in) begin
        next_state = ST_DONE; // data moves on grant
      end
      ST_DONE: if (!strobe) begin
        next_state = ST_IDLE; // host finished its cycle
      end
      default: next_state = ST_IDLE;
    endcase
  end
  always_ff @(posedge ref_clk_in or posedge reset_in) begin
    if (reset_in) begin
      state <= ST_IDLE;
    end else begin
      state <= next_state;
    end
  end
  // ready low holds the host until done; see R9
  wire next_ready = (next_state == ST_DONE) || (next_state == ST_IDLE && !sel);
  wire [15:0] status_word = {12'h000, processor_reset_ctl, proc_halt_in,
    proc_int_out, host_irq_flag}; // see R22
  // read mux for register area; undefined segment bits read as stored; see R13
  wire [15:0] reg_rdata = hit_seg ? movable_segment_pointer :
    hit_stat ? status_word : 16'h0000;
  // ==========================================================
  // outputs toward the host and the arbiter
  always_ff @(posedge ref_clk_in or posedge reset_in) begin
    if (reset_in) begin
      link.ready <= 1'b1;
      link.rdata <= 16'h0000;
      link.rdata_oe <= 1'b0;
      request_out <= 1'b0;
      board_addr_out <= 24'h000000;
      board_we_out <= 1'b0;
      board_wdata_out <= 16'h0000;
      proc_bus_oe_out <= 1'b1;
    end else begin
      link.ready <= next_ready;
      link.rdata_oe <= sel && !is_write;
      request_out <= (next_state == ST_WAIT); // see R9
      proc_bus_oe_out <= !(next_state == ST_WAIT); // float during host access; see R19
      board_addr_out <= formed_addr; // see R10 see R11 see R16
      board_we_out <= is_write;
      board_wdata_out <= link.wdata;
      if (state == ST_WAIT && grant_in) begin
        link.rdata <= mem_rdata_in; // data captured on grant
      end else if (start && !mem_area) begin
        link.rdata <= reg_rdata;
      end
    end
  end
  // ==========================================================
  // control registers, written once per cycle at its start
  wire wr_now = start && is_write && !mem_area;
  always_ff @(posedge ref_clk_in or posedge reset_in) begin
    if (reset_in) begin
      movable_segment_pointer <= SEG_RESET;
      processor_reset_ctl <= 1'b0;
      proc_int_out <= 1'b0;
    end else begin
      if (wr_now && hit_seg) begin
        movable_segment_pointer <= link.wdata; // see R10 see R13
      end
      if (wr_now && hit_rst) begin
        processor_reset_ctl <= link.wdata[0]; // see R17 see R23
      end
      if (wr_now && hit_pint) begin
        proc_int_out <= link.wdata[0]; // see R17
      end else if (proc_int_clear_in) begin
        proc_int_out <= 1'b0; // processor withdraws; see R17
      end
    end
  end
  // host interrupt: set wins over clear; see R18 see R21
  always_ff @(posedge ref_clk_in or posedge reset_in) begin
    if (reset_in) begin
      host_irq_flag <= 1'b0;
      link.host_irq <= 1'b0;
    end else begin
      if (proc_irq_raise_in) begin
        host_irq_flag <= 1'b1;
      end else if (wr_now && hit_clr) begin
        host_irq_flag <= 1'b0;
      end
      link.host_irq <= host_irq_flag;
    end
  end
  // nmi pulse of fixed length on any write to the nmi location; see R20
  always_ff @(posedge ref_clk_in or posedge reset_in) begin
    if (reset_in) begin
      nmi_cnt <= 8'h00;
      proc_nmi_out <= 1'b0;
    end else begin
      if (wr_now && hit_nmi) begin
        nmi_cnt <= 8'(NMI_PULSE_CYC);
      end else if (nmi_cnt != 8'h00) begin
        nmi_cnt <= nmi_cnt - 8'h01;
      end
      proc_nmi_out <= (wr_now && hit_nmi) || (nmi_cnt > 8'h01);
    end
  end
endmodule : hbw_board_end

// ---- design/hbw_host_end.sv ----
/*
  hbw_host_end: host controller driving word cycles into the board window.
  assumes: software uses Avalon-MM with waitrequest on the csr port.
*/
`timescale 1ns/1ps
module hbw_host_end
  import hbw_pkg::*;
(
  input wire logic ref_clk_in,
  input wire logic reset_in,
  hbw_link_if.host link,
  input wire logic [3:0] avs_address_in,
  input wire logic avs_read_in,
  input wire logic avs_write_in,
  input wire logic [31:0] avs_writedata_in,
  output logic [31:0] avs_readdata_out,
  output logic avs_waitrequest_out
);
  import hbw_pkg::*;
  typedef enum logic [2:0] {H_IDLE, H_ADDR, H_SETTLE, H_STROBE, H_END} hbw_hstate_e;
  hbw_hstate_e state;
  logic [23:0] addr_reg; // target byte address
  logic [15:0] wdata_reg; // data to write
  logic [15:0] rdata_reg; // data read back
  logic dir_write; // current cycle direction
  wire ack = !avs_waitrequest_out; // one-cycle answer to software
  // ==========================================================
  // csr decode
  wire req = avs_read_in || avs_write_in;
  wire go = avs_write_in && (avs_address_in == CSR_CMD) && ack && state == H_IDLE;
  wire [31:0] csr_rd = (avs_address_in == CSR_CMD) ? {31'h0, state != H_IDLE} :
    (avs_address_in == CSR_ADDR) ? {8'h00, addr_reg} :
    (avs_address_in == CSR_WDATA) ? {16'h0000, wdata_reg} :
    (avs_address_in == CSR_RDATA) ? {16'h0000, rdata_reg} :
    (avs_address_in == CSR_IRQ) ? {31'h0, link.host_irq} : 32'h0;
  // answer one cycle after the request; waitrequest low on the second edge
  always_ff @(posedge ref_clk_in or posedge reset_in) begin
    if (reset_in) begin
      avs_waitrequest_out <= 1'b1;
      avs_readdata_out <= 32'h0;
      addr_reg <= 24'h000000;
      wdata_reg <= 16'h0000;
      dir_write <= 1'b0;
    end else begin
      avs_waitrequest_out <= !(req && avs_waitrequest_out);
      avs_readdata_out <= csr_rd;
      if (avs_write_in && ack && avs_address_in == CSR_ADDR) begin
        addr_reg <= {avs_writedata_in[23:1], 1'b0}; // bit zero forced low; see R4
      end
      if (avs_write_in && ack && avs_address_in == CSR_WDATA) begin
        wdata_reg <= avs_writedata_in[15:0];
      end
      if (go) begin
        dir_write <= avs_writedata_in[0];
      end
    end
  end
  // ==========================================================
  // bus cycle: address with latch strobe, then strobe until ready
  always_ff @(posedge ref_clk_in or posedge reset_in) begin
    if (reset_in) begin
      state <= H_IDLE;
      link.host_addr <= 24'h000000;
      link.aen <= 1'b1;
      link.bale <= 1'b0;
      link.mem_rd_n <= 1'b1;
      link.mem_wr_n <= 1'b1;
      link.wdata <= 16'h0000;
      rdata_reg <= 16'h0000;
    end else begin
      case (state)
        H_IDLE: if (go) begin
          state <= H_ADDR;
          link.host_addr <= addr_reg; // word address only; see R4
          link.aen <= 1'b0;
          link.bale <= 1'b1;
          link.wdata <= wdata_reg;
        end
        H_ADDR: begin
          state <= H_SETTLE;
          link.bale <= 1'b0;
          link.mem_wr_n <= !dir_write;
          link.mem_rd_n <= dir_write;
        end
        H_SETTLE: begin
          state <= H_STROBE; // board updates ready on the same edge that first samples the strobe
        end
        H_STROBE: if (link.ready && link.word_capable_select_n == 1'b0) begin
          state <= H_END; // board released the cycle; see R9
          if (!dir_write) begin
            rdata_reg <= link.rdata;
          end
          link.mem_rd_n <= 1'b1;
          link.mem_wr_n <= 1'b1;
        end else if (link.ready && link.word_capable_select_n) begin
          state <= H_END; // no word indication: no word transfer made; see R6
          link.mem_rd_n <= 1'b1;
          link.mem_wr_n <= 1'b1;
        end
        H_END: begin
          state <= H_IDLE;
          link.aen <= 1'b1;
        end
        default: state <= H_IDLE;
      endcase
    end
  end
endmodule : hbw_host_end

// ---- tb/hbw_link_chk.sv ----
/*
  hbw_link_chk: timing relations on the wires between host and board ends.
  assumes: instantiated beside the link interface; one clock, reset active high.
*/
`timescale 1ns/1ps
module hbw_link_chk (
  input wire logic ref_clk_in,
  input wire logic reset_in,
  input wire logic [23:0] host_addr,
  input wire logic aen,
  input wire logic bale,
  input wire logic mem_rd_n,
  input wire logic mem_wr_n,
  input wire logic [15:0] wdata,
  input wire logic rdata_oe,
  input wire logic ready,
  input wire logic word_capable_select_n
);
  default clocking cb @(posedge ref_clk_in); endclocking
  default disable iff (reset_in);
  // either host strobe active
  wire strobe = !mem_rd_n || !mem_wr_n;
  // ==========================================================
  // sequences
  sequence s_strobe_on;
    $fell(mem_rd_n) || $fell(mem_wr_n);
  endsequence
  sequence s_hold;
    $fell(ready);
  endsequence
  // ==========================================================
  // assertions
  a_wcs_decode: assert property (
    !word_capable_select_n |-> host_addr[23:17] inside {7'h05, 7'h06, 7'h50})
    else $error("word select outside any base");
  a_strobe_excl: assert property (!(!mem_rd_n && !mem_wr_n))
    else $error("read and write strobes together");
  a_word_only: assert property (strobe |-> !host_addr[0])
    else $error("odd address during strobe");
  a_addr_hold: assert property (
    (strobe && $past(strobe)) |-> $stable(host_addr) && $stable(wdata))
    else $error("address or data moved in a cycle");
  a_ready_wait: assert property (!ready |-> strobe)
    else $error("host held without a strobe");
  a_ready_bound: assert property (s_hold |-> ##[1:100] ready)
    else $error("host held too long");
  a_idle_ready: assert property (aen |-> ready)
    else $error("ready low outside memory cycle");
  a_bale_lead: assert property (s_strobe_on |-> $past(bale) && !aen)
    else $error("strobe without latch strobe before");
  a_oe_write: assert property (!mem_wr_n |-> !rdata_oe)
    else $error("board drives data during write");
endmodule // hbw_link_chk

// ---- tb/test_host_bus_window_port.sv ----
/*
  test_host_bus_window_port: joins host and board ends, models arbiter and memory.
  assumes: design package and modules compiled first.
*/
`timescale 1ns/1ps
module test_host_bus_window_port;
  import hbw_pkg::*;
  // ==========================================================
  // stimulus and observed signals
  logic ref_clk_in = 1'b0;
  logic reset_in = 1'b1;
  logic [3:0] avs_address = 4'h0;
  logic avs_read = 1'b0;
  logic avs_write = 1'b0;
  logic [31:0] avs_writedata = 32'h0;
  logic [31:0] avs_readdata;
  logic avs_waitrequest;
  logic jumper_base_low_a = 1'b0;
  logic jumper_base_low_b = 1'b0;
  logic jumper_base_high = 1'b1;
  logic grant_in = 1'b0;
  logic [15:0] mem_rdata_in = 16'h0;
  logic proc_halt_in = 1'b0;
  logic proc_irq_raise_in = 1'b0;
  logic proc_int_clear_in = 1'b0;
  logic request_out, board_we_out, processor_reset_ctl, proc_nmi_out, proc_int_out;
  logic proc_bus_oe_out; // processor bus latches enabled
  logic [23:0] board_addr_out;
  logic [15:0] board_wdata_out;
  integer seed = 26619; // fixed seed
  int n_fail = 0;
  int total_checks = 0;
  int n_wr = 0; // granted board writes
  int nmi_len = 0; // cycles of nmi high
  logic [23:0] wr_addr = 24'h0;
  logic [15:0] wr_data = 16'h0;
  logic [23:0] base_t [3] = '{24'h0a0000, 24'h0d0000, 24'ha00000};
  // ==========================================================
  // design ends, link and checker
  hbw_link_if hbw_link_if_i ();
  hbw_host_end hbw_host_end_i (.ref_clk_in(ref_clk_in), .reset_in(reset_in),
    .link(hbw_link_if_i.host), .avs_address_in(avs_address), .avs_read_in(avs_read),
    .avs_write_in(avs_write), .avs_writedata_in(avs_writedata),
    .avs_readdata_out(avs_readdata), .avs_waitrequest_out(avs_waitrequest));
  hbw_board_end hbw_board_end_i (.ref_clk_in(ref_clk_in), .reset_in(reset_in),
    .link(hbw_link_if_i.board), .jumper_base_low_a(jumper_base_low_a),
    .jumper_base_low_b(jumper_base_low_b), .jumper_base_high(jumper_base_high),
    .grant_in(grant_in), .mem_rdata_in(mem_rdata_in), .proc_halt_in(proc_halt_in),
    .proc_irq_raise_in(proc_irq_raise_in), .proc_int_clear_in(proc_int_clear_in),
    .request_out(request_out), .board_addr_out(board_addr_out),
    .board_we_out(board_we_out), .board_wdata_out(board_wdata_out),
    .proc_bus_oe_out(proc_bus_oe_out),
    .processor_reset_ctl(processor_reset_ctl), .proc_nmi_out(proc_nmi_out),
    .proc_int_out(proc_int_out));
  hbw_link_chk hbw_link_chk_i (.ref_clk_in(ref_clk_in), .reset_in(reset_in),
    .host_addr(hbw_link_if_i.host_addr), .aen(hbw_link_if_i.aen), .bale(hbw_link_if_i.bale),
    .mem_rd_n(hbw_link_if_i.mem_rd_n), .mem_wr_n(hbw_link_if_i.mem_wr_n),
    .wdata(hbw_link_if_i.wdata), .rdata_oe(hbw_link_if_i.rdata_oe),
    .ready(hbw_link_if_i.ready), .word_capable_select_n(hbw_link_if_i.word_capable_select_n));
  // ==========================================================
  // expectation functions
  // memory content, blind to the unused lines 16 and 19
  function automatic logic [15:0] mem_f(input logic [23:0] a);
    logic [23:0] x;
    x = a & 24'hf6ffff;
    mem_f = x[15:0] ^ {x[23:16], x[23:16]};
  endfunction
  // board address for a window offset
  function automatic logic [23:0] exp_ba(input logic [15:0] ofs, input logic [15:0] seg);
    exp_ba = ofs[15] ? {FIXED_POINTER, ofs[13:1]} : {seg[9:0], ofs[14:1]};
  endfunction
  // ==========================================================
  // clock, arbiter with random latency, memory, capture
  initial begin
    forever #12.5 ref_clk_in = ~ref_clk_in;
  end
  always @(posedge ref_clk_in) begin
    grant_in <= request_out && ((32'($random(seed)) & 32'h3) != 32'h0);
    mem_rdata_in <= mem_f(board_addr_out);
    nmi_len <= proc_nmi_out ? nmi_len + 1 : nmi_len;
    if (request_out === 1'b1) check("bus float", 24'(proc_bus_oe_out), 24'h0);
    if (grant_in && request_out && board_we_out) begin
      n_wr <= n_wr + 1;
      wr_addr <= board_addr_out;
      wr_data <= board_wdata_out;
    end
  end
  // ==========================================================
  // tasks
  task automatic check(input string what, input logic [23:0] seen, input logic [23:0] exp);
    total_checks++;
    if (seen !== exp) begin
      n_fail++;
      $display("[ERR] %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic complete_run();
    $display("checks %0d mismatches %0d", total_checks, n_fail);
    if (n_fail == 0 && total_checks > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask
  // one avalon transfer, held until waitrequest is seen low
  task automatic avs(input logic [3:0] a, input logic rd, input logic [31:0] d,
    output logic [31:0] q);
    int n;
    avs_address <= a;
    avs_read <= rd;
    avs_write <= !rd;
    avs_writedata <= d;
    n = 0;
    do begin
      @(posedge ref_clk_in);
      n++;
    end while (avs_waitrequest !== 1'b0 && n < 50);
    q = avs_readdata;
    if (n >= 50) begin
      n_fail++;
      complete_run();
    end
    avs_read <= 1'b0;
    avs_write <= 1'b0;
    @(posedge ref_clk_in);
  endtask
  // one host word cycle through the controller
  task automatic hacc(input logic [23:0] a, input logic wr, input logic [15:0] d,
    output logic [15:0] q);
    logic [31:0] r;
    int n;
    avs(CSR_ADDR, 1'b0, {8'h00, a}, r);
    avs(CSR_WDATA, 1'b0, {16'h0000, d}, r);
    avs(CSR_CMD, 1'b0, {31'h0, wr}, r);
    n = 0;
    do begin
      avs(CSR_CMD, 1'b1, 32'h0, r);
      n++;
    end while (r[0] !== 1'b0 && n < 200);
    if (n >= 200) begin
      n_fail++;
      complete_run();
    end
    avs(CSR_RDATA, 1'b1, 32'h0, r);
    q = r[15:0];
  endtask
  // ==========================================================
  // main sequence
  initial begin
    logic [15:0] q, seg, d, ofs;
    logic [31:0] r;
    logic [23:0] a;
    int n0;
    repeat (10) @(posedge ref_clk_in);
    reset_in <= 1'b0;
    @(posedge ref_clk_in);
    // segment readback, restore, movable and fixed windows, double image
    // main traffic uses the high base, not the two low ones
    for (int k = 0; k < 12; k++) begin
      seg = (k == 0) ? 16'hffff : 16'($random(seed));
      hacc(24'ha0c000, 1'b1, seg, q);
      hacc(24'ha0c000, 1'b0, 16'h0, q);
      check("segment", 24'(q & SEG_DEFINED_MASK), 24'(seg & SEG_DEFINED_MASK));
      hacc(24'ha0c000, 1'b1, q, d);
      for (int j = 0; j < 2; j++) begin
        ofs = (k == 0) ? (j ? 16'hbffe : 16'h7ffe) : 16'($random(seed)) & 16'h3ffe;
        ofs = ofs | (j ? 16'h8000 : (16'($random(seed)) & 16'h4000));
        a = {7'h50, k[0], ofs};
        d = 16'($random(seed));
        hacc(a, 1'b1, d, q);
        check("board addr", wr_addr, exp_ba(ofs, seg) & 24'hf6ffff);
        check("board data", 24'(wr_data), 24'(d));
        hacc(a, 1'b0, 16'h0, q);
        check("read data", 24'(q), 24'(mem_f(exp_ba(ofs, seg))));
      end
    end
    // each jumper alone, every base tried with line 16 set
    for (int k = 0; k < 3; k++) begin
      {jumper_base_high, jumper_base_low_b, jumper_base_low_a} <= 3'(1 << k);
      for (int j = 0; j < 3; j++) begin
        n0 = n_wr;
        hacc(base_t[j] | 24'h018000, 1'b1, 16'h1234, q);
        check("decode", 24'(n_wr != n0), 24'(j == k));
      end
    end
    // control and status registers
    n0 = nmi_len;
    hacc(24'ha0c800, 1'b1, 16'h0000, q);
    check("nmi pulse", 24'(nmi_len - n0), 24'(NMI_PULSE_CYC));
    proc_halt_in <= 1'b1;
    hacc(24'ha0e000, 1'b1, 16'h0001, q);
    hacc(24'ha0e800, 1'b1, 16'h0001, q);
    proc_irq_raise_in <= 1'b1;
    @(posedge ref_clk_in);
    proc_irq_raise_in <= 1'b0;
    hacc(24'ha0d800, 1'b0, 16'h0, q);
    check("status set", 24'(q[3:0]), 24'hf);
    avs(CSR_IRQ, 1'b1, 32'h0, r);
    check("host irq", 24'(r[0]), 24'h1);
    repeat (RESET_HOLD_CYC) @(posedge ref_clk_in);
    hacc(24'ha0e000, 1'b1, 16'h0000, q);
    hacc(24'ha0d000, 1'b1, 16'h0000, q);
    check("irq cleared", 24'(hbw_link_if_i.host_irq), 24'h0);
    proc_int_clear_in <= 1'b1;
    proc_halt_in <= 1'b0;
    @(posedge ref_clk_in);
    proc_int_clear_in <= 1'b0;
    hacc(24'ha0d800, 1'b0, 16'h0, q);
    check("status clear", 24'(q[3:0]), 24'h0);
    complete_run();
  end
  // watchdog on the whole run
  initial begin
    repeat (90000) @(posedge ref_clk_in);
    n_fail++;
    complete_run();
  end
endmodule // test_host_bus_window_port
